// >>> pkg/sct_regs.vh
// Timing constants for the single-cycle core instruction sequencer.
// Included by the sequencer; holds definitions only.
//
// Function
// RQ1: Register-operand accumulator arithmetic takes 1 cycle.
// RQ2: Indirect-operand accumulator operation takes 2 cycles.
// RQ3: Immediate or direct accumulator operation: 2 bytes, 2 cycles.
// RQ4: Immediate into direct logic: 3 bytes, 3 cycles.
// RQ5: Data pointer load and increment take 3 cycles.
// RQ6: Accumulator-only single byte operations take 1 cycle (decimal adjust takes 2 in the sequencer).
// RQ7: Code memory read takes 4 cycles.
// RQ8: External data move takes 4 plus wait cycles.
// RQ9: External moves both ways, 8 or 16-bit address.
// RQ10: Stack push and pop: 2 bytes, 2 cycles.
// RQ11: Nibble exchange takes 2 cycles, one byte.
// RQ12: Carry and direct bit operations: 2 bytes, 2 cycles.
// RQ13: Long call 4 cycles, 3 on interrupt entry.
// RQ14: Short, absolute and conditional jumps take 3 cycles.
// RQ15: Compare branch unequal: 3 bytes, 4 cycles.
// RQ16: Register decrement branch nonzero: 2 bytes, 3 cycles.
// RQ17: Indirect sum jump takes 3 cycles.
// RQ18: Direct to direct move: 3 bytes, 3 cycles.
// RQ19: Bit test branch clear: 3 bytes, 4 cycles.
// RQ20: One counted cycle equals one core clock.
// RQ21: External wait count comes from programmable input.
// RQ22: Completion strobe in last cycle of instruction.

`ifndef SCT_REGS_VH
`define SCT_REGS_VH

// ***********************************************
// Code bytes per instruction
// ***********************************************
`define SCT_BYTES_0     2'h0
`define SCT_BYTES_1     2'h1
`define SCT_BYTES_2     2'h2
`define SCT_BYTES_3     2'h3

// ***********************************************
// Execution cycles per instruction class
// ***********************************************
`define SCT_CYC_SINGLE  4'h1
`define SCT_CYC_TWO     4'h2
`define SCT_CYC_THREE   4'h3
`define SCT_CYC_FOUR    4'h4
`define SCT_CYC_MULDIV  4'h9
`define SCT_CYC_EXT     4'h4
`define SCT_CYC_IRQCALL 4'h3

// ***********************************************
// Reset values
// ***********************************************
`define SCT_RST_CNT     9'h000
`define SCT_RST_IDX     2'h0

`endif

// >>> testbench/sct_ext_mem_model.sv
// External data memory seen from the sequencer's move strobes.
// Assumes accesses are separated by at least one idle cycle.
`timescale 1ns/1ps
module sct_ext_mem_model (
    input  logic       i_clk_sys,
    input  logic       i_rst_b,
    input  logic       i_ext_active,
    input  logic       i_ext_write,
    input  logic       i_ext_addr16,
    output logic [7:0] o_len,
    output logic       o_wr,
    output logic       o_a16
);
    logic prev_reg;
    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prev_reg <= 1'b0;
            o_len    <= 8'h00;
            o_wr     <= 1'b0;
            o_a16    <= 1'b0;
        end else begin
            prev_reg <= i_ext_active;
            if (i_ext_active) begin
                // Length of the access, direction and address width
                o_len <= prev_reg ? o_len + 8'h01 : 8'h01;
                o_wr  <= i_ext_write;
                o_a16 <= i_ext_addr16;
            end
        end
    end
endmodule // sct_ext_mem_model

// >>> testbench/sct_sequencer_sva.sv
// Timing checker for the instruction sequencer.
// Sees only the sequencer ports; attached by the bind at the foot.
`timescale 1ns/1ps
module sct_sequencer_sva #(
    parameter WAIT_W = 8
) (
    input logic              i_clk_sys,
    input logic              i_rst_b,
    input logic              i_opcode_valid,
    input logic [7:0]        i_opcode,
    input logic              i_irq_call,
    input logic [WAIT_W-1:0] i_external_wait_count,
    input logic              o_ready,
    input logic              o_busy,
    input logic              o_code_fetch,
    input logic [1:0]        o_fetch_index,
    input logic              o_instr_done,
    input logic              o_irq_entry,
    input logic              o_ext_active,
    input logic              o_ext_write,
    input logic              o_ext_addr16
);
    // Opcode taken this edge; an interrupt call wins over it
    wire acc = o_ready && i_opcode_valid && !i_irq_call;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    chk_done_ready: assert property (o_instr_done |-> o_ready && o_busy)
        else $error("done without ready or busy");
    chk_busy_holds: assert property (o_busy && !o_instr_done |=> o_busy)
        else $error("busy dropped before done");
    chk_take_busy: assert property (o_ready && (i_opcode_valid || i_irq_call) |=> o_busy)
        else $error("request not taken");
    chk_nop_one: assert property (acc && i_opcode == 8'h00 |=> o_instr_done)
        else $error("no-operation not one cycle");
    chk_irq_three: assert property (o_ready && i_irq_call |=>
        (o_irq_entry && !o_code_fetch && !o_instr_done)[*2] ##1 (o_irq_entry && o_instr_done))
        else $error("interrupt call length wrong");
    chk_ext_len: assert property (acc && i_opcode == 8'hE0 && i_external_wait_count == 0 |=>
        (o_ext_active && o_ext_addr16 && !o_ext_write && !o_instr_done)[*3] ##1 o_instr_done)
        else $error("external read length wrong");
    chk_cmp_fetch: assert property (acc && i_opcode == 8'hB4 |=>
        o_code_fetch[*3] ##1 (!o_code_fetch && o_instr_done))
        else $error("compare branch fetch wrong");
    chk_idle_quiet: assert property (!o_busy |-> o_ready && !o_code_fetch && !o_ext_active)
        else $error("idle outputs active");
endmodule // sct_sequencer_sva

bind sct_sequencer sct_sequencer_sva #(.WAIT_W(WAIT_W)) u_sva (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_opcode_valid(i_opcode_valid),
    .i_opcode(i_opcode), .i_irq_call(i_irq_call), .i_external_wait_count(i_external_wait_count),
    .o_ready(o_ready), .o_busy(o_busy), .o_code_fetch(o_code_fetch), .o_fetch_index(o_fetch_index),
    .o_instr_done(o_instr_done), .o_irq_entry(o_irq_entry), .o_ext_active(o_ext_active),
    .o_ext_write(o_ext_write), .o_ext_addr16(o_ext_addr16));

// >>> testbench/sct_sequencer_tb.sv
// Self-checking bench for the instruction sequencer.
// Assumes the checker is bound to the sequencer elsewhere.
`timescale 1ns/1ps
module sct_sequencer_tb;
    logic        i_clk_sys, i_rst_b, i_opcode_valid, i_irq_call;
    logic [7:0]  i_opcode, i_external_wait_count;
    wire         o_ready, o_busy, o_code_fetch, o_instr_done, o_irq_entry;
    wire         o_ext_active, o_ext_write, o_ext_addr16, m_wr, m_a16;
    wire [1:0]   o_fetch_index;
    wire [7:0]   m_len;
    integer      errors = 0, checks_done = 0, cycles = 0;
    // Opcode, byte count, cycle count
    logic [15:0] tab [0:45] = '{
        16'h2811, 16'h3811, 16'h2612, 16'h2522, 16'h2422, 16'h9422, 16'hE411, 16'hF411,
        16'hC411, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hD612,
        16'h5333, 16'h4333, 16'h6333, 16'h8533, 16'h9033, 16'hA313, 16'hC022, 16'hD022,
        16'h8222, 16'hB022, 16'h7222, 16'hA022, 16'hA222, 16'h9222,
        16'h8023, 16'h0123, 16'h1123, 16'h4023, 16'h5023, 16'h6023, 16'h7023, 16'hD823, 16'h7313,
        16'hB534, 16'hB434, 16'hB834, 16'hB634, 16'h1034, 16'h1234, 16'h9314, 16'h8314, 16'h0011};

    sct_sequencer #(.WAIT_W(8)) dut (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_opcode_valid(i_opcode_valid),
        .i_opcode(i_opcode), .i_irq_call(i_irq_call), .i_external_wait_count(i_external_wait_count),
        .o_ready(o_ready), .o_busy(o_busy), .o_code_fetch(o_code_fetch), .o_fetch_index(o_fetch_index),
        .o_instr_done(o_instr_done), .o_irq_entry(o_irq_entry), .o_ext_active(o_ext_active),
        .o_ext_write(o_ext_write), .o_ext_addr16(o_ext_addr16));
    sct_ext_mem_model u_mem (
        .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ext_active(o_ext_active),
        .i_ext_write(o_ext_write), .i_ext_addr16(o_ext_addr16), .o_len(m_len), .o_wr(m_wr), .o_a16(m_a16));

    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            give_verdict;
        end
    end

    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task give_verdict;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Entered just after an edge with o_ready high; leaves in the done cycle
    task run_op(input logic [7:0] op, input logic [7:0] n, input logic irq,
                input logic [3:0] cyc, input logic [1:0] byt);
        logic [15:0] bc, fc, ic;
        logic        dn;
        bc = 16'h0000;
        fc = 16'h0000;
        ic = 16'h0000;
        dn = 1'b0;
        i_opcode_valid = 1'b1;
        i_opcode = op;
        i_irq_call = irq;
        i_external_wait_count = n;
        @(posedge i_clk_sys);
        #1;
        // A one-cycle op is already done: the next call takes over the request
        if (o_instr_done !== 1'b1) begin
            i_opcode_valid = 1'b0;
            i_irq_call = 1'b0;
            // Late change must not stretch the running move
            i_external_wait_count = 8'hFF;
        end
        while (!dn && bc < 16'h0028) begin
            bc = bc + {15'h0000, o_busy === 1'b1};
            fc = fc + {15'h0000, o_code_fetch === 1'b1};
            ic = ic + {15'h0000, o_irq_entry === 1'b1};
            dn = (o_instr_done === 1'b1);
            check({14'h0000, o_fetch_index}, (bc > 16'h0003) ? 16'h0003 : bc - 16'h0001);
            if (!dn) begin
                @(posedge i_clk_sys);
                #1;
            end
        end
        check(bc, {12'h000, cyc});
        check(fc, {14'h0000, byt});
        check(ic, irq ? {12'h000, cyc} : 16'h0000);
        check({15'h0000, o_ready}, 16'h0001);
    endtask
    task run_tab(input logic [15:0] e);
        run_op(e[15:8], 8'h00, 1'b0, e[3:0], e[5:4]);
    endtask
    task run_ext(input logic [7:0] op, input logic [7:0] n, input logic wr, input logic a16);
        run_op(op, n, 1'b0, 4'h4 + n[3:0], 2'h1);
        @(posedge i_clk_sys);
        #1;
        check({8'h00, m_len}, 16'h0004 + {8'h00, n});
        check({15'h0000, m_wr}, {15'h0000, wr});
        check({15'h0000, m_a16}, {15'h0000, a16});
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    task sc_acc;
        run_tab(16'h4422);
        run_tab(16'h1411);
        for (int i = 0; i < 14; i++) run_tab(tab[i]);
    endtask
    task sc_direct;
        for (int i = 14; i < 22; i++) run_tab(tab[i]);
    endtask
    task sc_bits;
        for (int i = 22; i < 28; i++) run_tab(tab[i]);
    endtask
    task sc_branch;
        for (int i = 28; i < 37; i++) run_tab(tab[i]);
    endtask
    task sc_long;
        for (int i = 37; i < 46; i++) run_tab(tab[i]);
    endtask
    task sc_ext;
        run_ext(8'hE2, 8'h02, 1'b0, 1'b0);
        run_ext(8'hE0, 8'h00, 1'b0, 1'b1);
        run_ext(8'hF2, 8'h05, 1'b1, 1'b0);
        run_ext(8'hF0, 8'h01, 1'b1, 1'b1);
    endtask
    task sc_irq;
        // Opcode offered at the same edge loses to the inserted call
        run_op(8'h12, 8'h00, 1'b1, 4'h3, 2'h0);
    endtask
    task sc_reset;
        i_opcode_valid = 1'b1;
        i_opcode = 8'hF0;
        i_external_wait_count = 8'h05;
        @(posedge i_clk_sys);
        #1;
        i_opcode_valid = 1'b0;
        @(posedge i_clk_sys);
        #1;
        i_rst_b = 1'b0;
        #1;
        check({14'h0000, o_busy, o_ext_active}, 16'h0000);
        check({15'h0000, o_ready}, 16'h0001);
        @(posedge i_clk_sys);
        #1;
        i_rst_b = 1'b1;
        run_tab(tab[45]);
    endtask

    initial begin
        i_rst_b = 1'b0;
        i_opcode_valid = 1'b0;
        i_irq_call = 1'b0;
        i_opcode = 8'h00;
        i_external_wait_count = 8'h00;
        repeat (2) @(posedge i_clk_sys);
        #1;
        i_rst_b = 1'b1;
        sc_acc;
        sc_direct;
        sc_bits;
        sc_branch;
        sc_long;
        sc_irq;
        sc_ext;
        sc_reset;
        give_verdict;
    end
endmodule // sct_sequencer_tb

// >>> verilog/sct_sequencer.v
// Instruction timing sequencer of an 8-bit single-cycle core.
// Assumes the fetch logic presents each opcode on the core clock and
// accepts it only while o_ready is high; no clock-domain crossing here.
// The wait count must be steady at the edge that takes a move.
`timescale 1ns/1ps
`include "sct_regs.vh"

module sct_sequencer #(
    parameter WAIT_W = 8
) (
    input  wire              i_clk_sys,
    input  wire              i_rst_b,
    input  wire              i_opcode_valid,
    input  wire [7:0]        i_opcode,
    input  wire              i_irq_call,
    input  wire [WAIT_W-1:0] i_external_wait_count,
    output reg               o_ready,
    output reg               o_busy,
    output reg               o_code_fetch,
    output reg  [1:0]        o_fetch_index,
    output reg               o_instr_done,
    output reg               o_irq_entry,
    output reg               o_ext_active,
    output reg               o_ext_write,
    output reg               o_ext_addr16
);

    // ***********************************************
    // Opcode decode
    // ***********************************************
    reg [1:0] dec_bytes;
    reg [3:0] dec_cyc;
    reg       dec_ext;
    reg       dec_ext_wr;
    reg       dec_ext_a16;

    always @* begin
        dec_bytes   = `SCT_BYTES_1;
        dec_cyc     = `SCT_CYC_SINGLE;
        dec_ext     = 1'b0;
        dec_ext_wr  = 1'b0;
        dec_ext_a16 = 1'b0;
        casez (i_opcode)
            // Register operand rows with longer forms
            8'b0111_1???: begin
                dec_bytes = `SCT_BYTES_2;
                dec_cyc   = `SCT_CYC_TWO;
            end
            // Moves between a register and a direct byte
            8'b1000_1???, 8'b1010_1???: begin
                dec_bytes = `SCT_BYTES_2;
                dec_cyc   = `SCT_CYC_TWO;
            end
            8'b1011_1???: begin
                dec_bytes = `SCT_BYTES_3; // RQ15
                dec_cyc   = `SCT_CYC_FOUR;
            end
            8'b1101_1???: begin
                dec_bytes = `SCT_BYTES_2; // RQ16
                dec_cyc   = `SCT_CYC_THREE;
            end
            8'b????_1???: begin
                dec_bytes = `SCT_BYTES_1; // RQ1
                dec_cyc   = `SCT_CYC_SINGLE;
            end
            // Indirect operand rows
            8'b0111_011?, 8'b1000_011?, 8'b1010_011?: begin
                dec_bytes = `SCT_BYTES_2;
                dec_cyc   = `SCT_CYC_TWO;
            end
            8'b1011_011?: begin
                dec_bytes = `SCT_BYTES_3; // RQ15
                dec_cyc   = `SCT_CYC_FOUR;
            end
            8'b1101_011?: begin
                dec_bytes = `SCT_BYTES_1; // RQ11
                dec_cyc   = `SCT_CYC_TWO;
            end
            8'b????_011?: begin
                dec_bytes = `SCT_BYTES_1; // RQ2
                dec_cyc   = `SCT_CYC_TWO;
            end
            // External data moves, 8-bit pointer address
            8'b111?_001?: begin
                dec_cyc    = `SCT_CYC_EXT; // RQ8
                dec_ext    = 1'b1;         // RQ9
                dec_ext_wr = i_opcode[4];
            end
            // External data moves, 16-bit data pointer address
            8'b111?_0000: begin
                dec_cyc     = `SCT_CYC_EXT; // RQ8
                dec_ext     = 1'b1;         // RQ9
                dec_ext_wr  = i_opcode[4];
                dec_ext_a16 = 1'b1;
            end
            // Direct byte forms
            8'b1000_0101, 8'b0111_0101: begin
                dec_bytes = `SCT_BYTES_3; // RQ18
                dec_cyc   = `SCT_CYC_THREE;
            end
            8'b1011_0101: begin
                dec_bytes = `SCT_BYTES_3; // RQ15
                dec_cyc   = `SCT_CYC_FOUR;
            end
            // Decrement direct byte and branch
            8'b1101_0101: begin
                dec_bytes = `SCT_BYTES_3;
                dec_cyc   = `SCT_CYC_FOUR;
            end
            // Reserved code runs as a one-cycle no-operation
            8'b1010_0101: begin
                dec_bytes = `SCT_BYTES_1;
                dec_cyc   = `SCT_CYC_SINGLE;
            end
            8'b????_0101: begin
                dec_bytes = `SCT_BYTES_2; // RQ3
                dec_cyc   = `SCT_CYC_TWO;
            end
            // Immediate and accumulator-only forms
            // Immediate operand to accumulator; decrement stays single byte
            8'b0?10_0100, 8'b0?11_0100, 8'b010?_0100, 8'b1001_0100,
            8'b0111_0100: begin
                dec_bytes = `SCT_BYTES_2; // RQ3
                dec_cyc   = `SCT_CYC_TWO;
            end
            // Multiply and divide hold the core longest apart from external moves with long waits
            8'b1000_0100, 8'b1010_0100: begin
                dec_cyc = `SCT_CYC_MULDIV;
            end
            // Decimal adjust needs a second cycle for the fix-up
            8'b1101_0100: begin
                dec_cyc = `SCT_CYC_TWO;
            end
            8'b1011_0100: begin
                dec_bytes = `SCT_BYTES_3; // RQ15
                dec_cyc   = `SCT_CYC_FOUR;
            end
            8'b????_0100: begin
                dec_bytes = `SCT_BYTES_1; // RQ6
                dec_cyc   = `SCT_CYC_SINGLE;
            end
            // Column three
            8'b01??_0011: begin
                if (i_opcode[5:4] == 2'h3) begin
                    dec_cyc = `SCT_CYC_THREE; // RQ17
                end else begin
                    dec_bytes = `SCT_BYTES_3; // RQ4
                    dec_cyc   = `SCT_CYC_THREE;
                end
            end
            8'b100?_0011: begin
                dec_cyc = `SCT_CYC_FOUR; // RQ7
            end
            8'b1010_0011: begin
                dec_cyc = `SCT_CYC_THREE; // RQ5
            end
            8'b????_0011: begin
                dec_cyc = `SCT_CYC_SINGLE; // RQ6
            end
            // Column two
            8'b0000_0010, 8'b0001_0010: begin
                dec_bytes = `SCT_BYTES_3; // RQ13
                dec_cyc   = `SCT_CYC_FOUR;
            end
            // Returns pop both address bytes
            8'b001?_0010: begin
                dec_cyc = `SCT_CYC_FOUR;
            end
            8'b????_0010: begin
                dec_bytes = `SCT_BYTES_2; // RQ12
                dec_cyc   = `SCT_CYC_TWO;
            end
            // Absolute jumps and calls
            8'b????_0001: begin
                dec_bytes = `SCT_BYTES_2; // RQ14
                dec_cyc   = `SCT_CYC_THREE;
            end
            // Column zero
            8'b0000_0000: begin
                dec_cyc = `SCT_CYC_SINGLE; // RQ20
            end
            8'b00??_0000: begin
                dec_bytes = `SCT_BYTES_3; // RQ19
                dec_cyc   = `SCT_CYC_FOUR;
            end
            8'b01??_0000, 8'b1000_0000: begin
                dec_bytes = `SCT_BYTES_2; // RQ14
                dec_cyc   = `SCT_CYC_THREE;
            end
            8'b1001_0000: begin
                dec_bytes = `SCT_BYTES_3; // RQ5
                dec_cyc   = `SCT_CYC_THREE;
            end
            8'b110?_0000: begin
                dec_bytes = `SCT_BYTES_2; // RQ10
                dec_cyc   = `SCT_CYC_TWO;
            end
            8'b101?_0000: begin
                dec_bytes = `SCT_BYTES_2; // RQ12
                dec_cyc   = `SCT_CYC_TWO;
            end
            // Unreachable: every code is listed above
            default: begin
                dec_bytes = `SCT_BYTES_1;
                dec_cyc   = `SCT_CYC_SINGLE;
            end
        endcase
    end

    // ***********************************************
    // Sequencer state
    // ***********************************************
    // One bit wider than the wait count so 4 + n never wraps
    localparam CNT_W = WAIT_W + 1;

    reg             busy_reg;
    reg             busy_next;
    reg [CNT_W-1:0] cnt_reg;
    reg [CNT_W-1:0] cnt_next;
    reg [1:0]       idx_reg;
    reg [1:0]       idx_next;
    reg [1:0]       bytes_reg;
    reg [1:0]       bytes_next;
    reg             ext_reg;
    reg             ext_next;
    reg             wr_reg;
    reg             wr_next;
    reg             a16_reg;
    reg             a16_next;
    reg             irq_reg;
    reg             irq_next;
    reg [CNT_W-1:0] total_cyc;

    wire start = o_ready & (i_irq_call | i_opcode_valid);

    // Wait states stretch only external moves; width grows with WAIT_W
    always @* begin
        total_cyc = {{(CNT_W-4){1'b0}}, dec_cyc};
        if (dec_ext) begin
            total_cyc = {{(CNT_W-4){1'b0}}, dec_cyc}
                      + {1'b0, i_external_wait_count}; // RQ21
        end
    end

    always @* begin
        busy_next  = busy_reg;
        cnt_next   = cnt_reg;
        idx_next   = idx_reg;
        bytes_next = bytes_reg;
        ext_next   = ext_reg;
        wr_next    = wr_reg;
        a16_next   = a16_reg;
        irq_next   = irq_reg;
        if (start) begin
            busy_next = 1'b1;
            idx_next  = `SCT_RST_IDX;
            if (i_irq_call) begin
                // Interrupt entry wins over a fetched opcode
                cnt_next   = {{(CNT_W-4){1'b0}}, `SCT_CYC_IRQCALL} - 1'b1; // RQ13
                // No code bytes; the target comes from the vector
                bytes_next = `SCT_BYTES_0;
                ext_next   = 1'b0;
                wr_next    = 1'b0;
                a16_next   = 1'b0;
                irq_next   = 1'b1;
            end else begin
                // Wait count taken here only; later changes cannot stretch a move
                cnt_next   = total_cyc - 1'b1; // RQ8
                bytes_next = dec_bytes;
                ext_next   = dec_ext;
                wr_next    = dec_ext_wr;
                a16_next   = dec_ext_a16;
                irq_next   = 1'b0;
            end
        end else if (busy_reg && cnt_reg != `SCT_RST_CNT) begin
            // One count per clock
            cnt_next = cnt_reg - 1'b1; // RQ20
            // Index saturates; no instruction has more than three bytes
            if (idx_reg != 2'h3) begin
                idx_next = idx_reg + 2'h1;
            end
        end else if (busy_reg) begin
            // Last cycle passed with no new request: go idle
            busy_next = 1'b0;
            ext_next  = 1'b0;
            irq_next  = 1'b0;
        end
    end

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_reg  <= 1'b0;
            cnt_reg   <= `SCT_RST_CNT;
            idx_reg   <= `SCT_RST_IDX;
            bytes_reg <= `SCT_BYTES_0;
            ext_reg   <= 1'b0;
            wr_reg    <= 1'b0;
            a16_reg   <= 1'b0;
            irq_reg   <= 1'b0;
        end else begin
            busy_reg  <= busy_next;
            cnt_reg   <= cnt_next;
            idx_reg   <= idx_next;
            bytes_reg <= bytes_next;
            ext_reg   <= ext_next;
            wr_reg    <= wr_next;
            a16_reg   <= a16_next;
            irq_reg   <= irq_next;
        end
    end

    // ***********************************************
    // Registered outputs
    // ***********************************************
    // Outputs are built from next state so they line up with it
    wire last_next = busy_next && (cnt_next == `SCT_RST_CNT);

    always @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ready       <= 1'b1;
            o_busy        <= 1'b0;
            o_code_fetch  <= 1'b0;
            o_fetch_index <= `SCT_RST_IDX;
            o_instr_done  <= 1'b0;
            o_irq_entry   <= 1'b0;
            o_ext_active  <= 1'b0;
            o_ext_write   <= 1'b0;
            o_ext_addr16  <= 1'b0;
        end else begin
            // Ready in the last cycle lets instructions run back to back
            o_ready       <= !busy_next || last_next;
            o_busy        <= busy_next;
            // Fetch strobe only while code bytes remain
            o_code_fetch  <= busy_next && (idx_next < bytes_next);
            o_fetch_index <= idx_next;
            o_instr_done  <= last_next; // RQ22
            o_irq_entry   <= busy_next && irq_next;
            o_ext_active  <= busy_next && ext_next; // RQ9
            o_ext_write   <= busy_next && ext_next && wr_next;
            o_ext_addr16  <= busy_next && ext_next && a16_next;
        end
    end

endmodule // sct_sequencer
